// ---- hw/fmac_lane_mul.sv ----
// One Q15 halfword lane: signed integer product and saturating Q31 product.
// Purely combinational; the caller registers whatever it keeps.
`timescale 1ns/1ps
module fmac_lane_mul (
  input  wire logic [15:0] a_i,     // First source halfword
  input  wire logic [15:0] b_i,     // Second source halfword
  output logic      [31:0] prod_o,  // Signed integer product
  output logic      [31:0] q31_o,   // Product shifted left, saturated
  output logic             sat_o    // Both inputs were the Q15 minimum
);

  logic signed [31:0] prod;

  // Full signed product fits 32 bits for two halfwords
  assign prod   = $signed(a_i) * $signed(b_i);
  assign prod_o = prod;
  assign sat_o  = (a_i == fmac_pkg::FMAC_MIN_Q15) && (b_i == fmac_pkg::FMAC_MIN_Q15);
  // Only minus one times minus one overflows the shift
  assign q31_o  = sat_o ? fmac_pkg::FMAC_MAX_Q31 : {prod[30:0], 1'b0};

endmodule

// ---- hw/fmac_pkg.sv ----
// Package for the fractional multiply-accumulate unit: opcodes, exception codes,
// register offsets, field positions and reset values.
// Assumes a 32-bit Avalon-MM slave with byte addresses and one clock domain.
package fmac_pkg;

  // Multiply operations issued by the pipeline
  typedef enum logic [2:0] {
    FMAC_OP_FRAC_WORD_SAT_MULTIPLY        = 3'h0,
    FMAC_OP_FRAC_HALFWORD_VECTOR_MULTIPLY = 3'h1,
    FMAC_OP_INT_HALFWORD_MUL_SUB_ACC      = 3'h2,
    FMAC_OP_FRAC_HALFWORD_MUL_SUB_ACC_SAT = 3'h3,
    FMAC_OP_SIGNED_WORD_MULTIPLY_TO_ACC   = 3'h4
  } fmac_op_t;

  // Exception answer codes
  localparam logic [1:0] FMAC_EXC_NONE     = 2'h0;
  localparam logic [1:0] FMAC_EXC_RESERVED = 2'h1;
  localparam logic [1:0] FMAC_EXC_DSP_DIS  = 2'h2;

  // Saturation operands and results
  localparam logic [31:0] FMAC_MIN_Q31 = 32'h80000000;
  localparam logic [31:0] FMAC_MAX_Q31 = 32'h7fffffff;
  localparam logic [15:0] FMAC_MIN_Q15 = 16'h8000;

  // Register byte offsets
  localparam logic [5:0] FMAC_REG_CTRL       = 6'h00;
  localparam logic [5:0] FMAC_REG_SPCR       = 6'h04;
  localparam logic [5:0] FMAC_REG_IRQ_STATUS = 6'h08;
  localparam logic [5:0] FMAC_REG_IRQ_MASK   = 6'h0c;
  localparam logic [5:0] FMAC_REG_ACC_BASE   = 6'h20;

  // Control register fields
  localparam int         FMAC_CTRL_EN_BIT   = 0;
  localparam logic [0:0] FMAC_CTRL_EN_RESET = 1'h1;

  // Overflow flag field of the signal-processing control register
  localparam int         FMAC_OVF_LSB       = 16;
  localparam int         FMAC_OVF_MSB       = 23;
  localparam int         FMAC_OVF_WORD_BIT  = 21;
  localparam logic [7:0] FMAC_OVF_RESET     = 8'h00;

  // Interrupt status bits
  localparam int         FMAC_IRQ_WORD_SAT  = 0;
  localparam int         FMAC_IRQ_ACC_SAT   = 1;
  localparam int         FMAC_IRQ_EXC       = 2;
  localparam int         FMAC_IRQ_W         = 3;
  localparam logic [2:0] FMAC_IRQ_RESET     = 3'h0;

endpackage

// ---- hw/fmac_unit.sv ----
// Fractional multiply-accumulate unit: multiply datapath, four accumulators,
// overflow flags, Avalon-MM register slave and one interrupt line.
// Assumes the issuing pipeline runs on core_clk_i and holds nothing across cycles.
//
// Design decisions made here: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
module fmac_unit #(
  parameter int NUM_ACC = 4                    // Accumulator count
) (
  input  wire logic        core_clk_i,         // Core clock, 100 MHz
  input  wire logic        rstn_i,             // Asynchronous reset, active low
  // Issue port from the pipeline
  input  wire logic        op_valid_i,         // Operation issued this cycle
  input  wire logic [2:0]  op_code_i,          // Operation code
  input  wire logic [1:0]  acc_sel_i,          // Accumulator select
  input  wire logic [31:0] src_a_i,            // First source register value
  input  wire logic [31:0] src_b_i,            // Second source register value
  // Answer to the pipeline
  output logic             res_valid_o,        // Operation completed, one cycle
  output logic             res_gpr_we_o,       // Result targets a general register
  output logic [31:0]      res_data_o,         // General register result
  output logic             exc_valid_o,        // Exception raised, one cycle
  output logic [1:0]       exc_code_o,         // Exception kind
  // Avalon-MM slave
  input  wire logic [5:0]  avs_address_i,      // Byte address
  input  wire logic        avs_read_i,         // Read request
  input  wire logic        avs_write_i,        // Write request
  input  wire logic [31:0] avs_writedata_i,    // Write data
  input  wire logic [3:0]  avs_byteenable_i,   // Byte lanes
  output logic [31:0]      avs_readdata_o,     // Read data
  output logic             avs_waitrequest_o,  // Stall
  output logic             irq_o               // Interrupt, level
);

  localparam int FMAC_IRQ_W = fmac_pkg::FMAC_IRQ_W;

  // Reset synchroniser
  logic rst_meta_q;
  logic rst_sync_q;
  logic rst_n;

  // Datapath
  logic                  op_legal;
  logic                  need_check;
  logic                  go;
  logic                  exc_any;
  logic [1:0]            exc_code_d;
  logic signed [63:0]    w_prod;
  logic                  w_sat;
  logic [31:0]           w_res;
  logic [31:0]           hi_prod;
  logic [31:0]           hi_q31;
  logic                  hi_sat;
  logic [31:0]           lo_prod;
  logic [31:0]           lo_q31;
  logic                  lo_sat;
  logic [32:0]           int_diff;
  logic [32:0]           frac_diff;
  logic [63:0]           acc_cur;
  logic [63:0]           acc_new;
  logic                  acc_we;
  logic [7:0]            ovf_set;
  logic [FMAC_IRQ_W-1:0] irq_set;

  // Registers
  logic [31:0]           acc_hi_q [NUM_ACC];
  logic [31:0]           acc_lo_q [NUM_ACC];
  logic                  dsp_en_q;
  logic [7:0]            ovf_q;
  logic [FMAC_IRQ_W-1:0] irq_status_q;
  logic [FMAC_IRQ_W-1:0] irq_mask_q;

  // Bus
  logic                  bus_req;
  logic                  bus_wr;
  logic [31:0]           wmask;
  logic [31:0]           rd_data;
  logic [2:0]            irq_wmask_lo;

  // Reset release through two flops; the assertion stays asynchronous
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end
  assign rst_n = rst_sync_q;

  // Access check; the word multiply to the original pair skips it
  always_comb begin
    op_legal   = 1'b0;
    need_check = 1'b1;
    unique case (op_code_i)
      fmac_pkg::FMAC_OP_FRAC_WORD_SAT_MULTIPLY,
      fmac_pkg::FMAC_OP_FRAC_HALFWORD_VECTOR_MULTIPLY,
      fmac_pkg::FMAC_OP_INT_HALFWORD_MUL_SUB_ACC,
      fmac_pkg::FMAC_OP_FRAC_HALFWORD_MUL_SUB_ACC_SAT: begin
        op_legal = 1'b1;
      end
      fmac_pkg::FMAC_OP_SIGNED_WORD_MULTIPLY_TO_ACC: begin
        op_legal   = 1'b1;
        need_check = (acc_sel_i != 2'h0);
      end
      default: begin
        op_legal = 1'b0;
      end
    endcase
  end

  // Exceptions come only from legality and enable, never from operand data
  always_comb begin
    exc_code_d = fmac_pkg::FMAC_EXC_NONE;
    if (op_valid_i && !op_legal) begin
      exc_code_d = fmac_pkg::FMAC_EXC_RESERVED;
    end else if (op_valid_i && need_check && !dsp_en_q) begin
      exc_code_d = fmac_pkg::FMAC_EXC_DSP_DIS;
    end
  end
  assign exc_any = (exc_code_d != fmac_pkg::FMAC_EXC_NONE);
  assign go      = op_valid_i && !exc_any;

  // Word product shared by the Q31 and accumulator multiplies
  assign w_prod = $signed(src_a_i) * $signed(src_b_i);
  assign w_sat  = (src_a_i == fmac_pkg::FMAC_MIN_Q31) &&
                  (src_b_i == fmac_pkg::FMAC_MIN_Q31);
  // Shift left one then upper word equals product bits 62..31
  assign w_res  = w_sat ? fmac_pkg::FMAC_MAX_Q31 : w_prod[62:31];

  // Left lanes
  fmac_lane_mul u_lane_hi (
    .a_i    (src_a_i[31:16]),
    .b_i    (src_b_i[31:16]),
    .prod_o (hi_prod),
    .q31_o  (hi_q31),
    .sat_o  (hi_sat)
  );

  // Right lanes
  fmac_lane_mul u_lane_lo (
    .a_i    (src_a_i[15:0]),
    .b_i    (src_b_i[15:0]),
    .prod_o (lo_prod),
    .q31_o  (lo_q31),
    .sat_o  (lo_sat)
  );

  // Differences kept at 33 bits so no sum wraps before extension
  assign int_diff  = {hi_prod[31], hi_prod} - {lo_prod[31], lo_prod};
  assign frac_diff = {hi_q31[31], hi_q31} - {lo_q31[31], lo_q31};
  assign acc_cur   = {acc_hi_q[acc_sel_i], acc_lo_q[acc_sel_i]};

  // Accumulator next value and flag events per operation
  always_comb begin
    acc_new = acc_cur;
    acc_we  = 1'b0;
    ovf_set = 8'h00;
    irq_set = '0;
    if (go) begin
      unique case (op_code_i)
        fmac_pkg::FMAC_OP_FRAC_WORD_SAT_MULTIPLY: begin
          ovf_set[fmac_pkg::FMAC_OVF_WORD_BIT - fmac_pkg::FMAC_OVF_LSB] = w_sat;
          irq_set[fmac_pkg::FMAC_IRQ_WORD_SAT] = w_sat;
        end
        fmac_pkg::FMAC_OP_FRAC_HALFWORD_VECTOR_MULTIPLY: begin
          ovf_set[fmac_pkg::FMAC_OVF_WORD_BIT - fmac_pkg::FMAC_OVF_LSB] =
            hi_sat | lo_sat;
          irq_set[fmac_pkg::FMAC_IRQ_WORD_SAT] = hi_sat | lo_sat;
        end
        fmac_pkg::FMAC_OP_INT_HALFWORD_MUL_SUB_ACC: begin
          // No overflow flag is touched here
          acc_new = acc_cur + {{31{int_diff[32]}}, int_diff};
          acc_we  = 1'b1;
        end
        fmac_pkg::FMAC_OP_FRAC_HALFWORD_MUL_SUB_ACC_SAT: begin
          acc_new = acc_cur + {{31{frac_diff[32]}}, frac_diff};
          acc_we  = 1'b1;
          ovf_set[acc_sel_i] = hi_sat | lo_sat;
          irq_set[fmac_pkg::FMAC_IRQ_ACC_SAT] = hi_sat | lo_sat;
        end
        fmac_pkg::FMAC_OP_SIGNED_WORD_MULTIPLY_TO_ACC: begin
          acc_new = w_prod;
          acc_we  = 1'b1;
        end
        default: begin
          acc_we = 1'b0;
        end
      endcase
    end
    irq_set[fmac_pkg::FMAC_IRQ_EXC] = exc_any;
  end

  // Accumulators; register-targeting multiplies leave all four alone,
  // which is one legal choice for the undefined accumulator zero
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_ACC; i++) begin
        acc_hi_q[i] <= 32'h00000000;
        acc_lo_q[i] <= 32'h00000000;
      end
    end else if (acc_we) begin
      acc_hi_q[acc_sel_i] <= acc_new[63:32];
      acc_lo_q[acc_sel_i] <= acc_new[31:0];
    end
  end

  // Answer to the pipeline, one cycle after issue
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      res_valid_o  <= 1'b0;
      res_gpr_we_o <= 1'b0;
      res_data_o   <= 32'h00000000;
      exc_valid_o  <= 1'b0;
      exc_code_o   <= fmac_pkg::FMAC_EXC_NONE;
    end else begin
      res_valid_o  <= go;
      res_gpr_we_o <= go && (op_code_i == fmac_pkg::FMAC_OP_FRAC_WORD_SAT_MULTIPLY ||
                             op_code_i == fmac_pkg::FMAC_OP_FRAC_HALFWORD_VECTOR_MULTIPLY);
      exc_valid_o  <= exc_any;
      exc_code_o   <= exc_code_d;
      if (go && op_code_i == fmac_pkg::FMAC_OP_FRAC_WORD_SAT_MULTIPLY) begin
        res_data_o <= w_res;
      end else if (go && op_code_i == fmac_pkg::FMAC_OP_FRAC_HALFWORD_VECTOR_MULTIPLY) begin
        res_data_o <= {hi_q31[31:16], lo_q31[31:16]};
      end
    end
  end

  // Bus handshake: one wait cycle, then the access completes
  assign bus_req = avs_read_i || avs_write_i;
  assign bus_wr  = avs_write_i && !avs_waitrequest_o;
  assign wmask   = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                    {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
  assign irq_wmask_lo = avs_writedata_i[2:0] & wmask[2:0];

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= !(bus_req && avs_waitrequest_o);
    end
  end

  // Enable bit gates the access check
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      dsp_en_q <= fmac_pkg::FMAC_CTRL_EN_RESET;
    end else if (bus_wr && avs_address_i == fmac_pkg::FMAC_REG_CTRL && wmask[0]) begin
      dsp_en_q <= avs_writedata_i[fmac_pkg::FMAC_CTRL_EN_BIT];
    end
  end

  // Overflow field: software may overwrite it, but a hardware set wins
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ovf_q <= fmac_pkg::FMAC_OVF_RESET;
    end else if (bus_wr && avs_address_i == fmac_pkg::FMAC_REG_SPCR) begin
      ovf_q <= ((ovf_q & ~wmask[23:16]) | (avs_writedata_i[23:16] & wmask[23:16]))
               | ovf_set;
    end else begin
      ovf_q <= ovf_q | ovf_set;
    end
  end

  // Sticky status, cleared by writing one; a same-cycle event stays set
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_status_q <= fmac_pkg::FMAC_IRQ_RESET;
    end else if (bus_wr && avs_address_i == fmac_pkg::FMAC_REG_IRQ_STATUS) begin
      irq_status_q <= (irq_status_q & ~irq_wmask_lo) | irq_set;
    end else begin
      irq_status_q <= irq_status_q | irq_set;
    end
  end

  // Interrupt mask
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask_q <= fmac_pkg::FMAC_IRQ_RESET;
    end else if (bus_wr && avs_address_i == fmac_pkg::FMAC_REG_IRQ_MASK) begin
      irq_mask_q <= (irq_mask_q & ~wmask[2:0]) | irq_wmask_lo;
    end
  end

  // Interrupt line lags the status by one cycle
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_status_q & irq_mask_q);
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    rd_data = 32'h00000000;
    if (avs_address_i[5]) begin
      // Accumulator window: eight bytes each, upper half first
      rd_data = avs_address_i[2] ? acc_lo_q[avs_address_i[4:3]]
                                 : acc_hi_q[avs_address_i[4:3]];
    end else begin
      unique case (avs_address_i)
        fmac_pkg::FMAC_REG_CTRL:       rd_data = {31'h0, dsp_en_q};
        fmac_pkg::FMAC_REG_SPCR:       rd_data = {8'h00, ovf_q, 16'h0000};
        fmac_pkg::FMAC_REG_IRQ_STATUS: rd_data = {29'h0, irq_status_q};
        fmac_pkg::FMAC_REG_IRQ_MASK:   rd_data = {29'h0, irq_mask_q};
        default:                       rd_data = 32'h00000000;
      endcase
    end
  end

  // Read data captured as waitrequest falls, held until the next read
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata_o <= 32'h00000000;
    end else if (avs_read_i && avs_waitrequest_o) begin
      avs_readdata_o <= rd_data;
    end
  end

endmodule

// ---- verif/fmac_pipe_model.sv ----
// Pipeline model: issues decoded multiplies and tallies the unit's answers.
// Assumes one bench process calls its tasks, only after reset release.
`timescale 1ns/1ps
module fmac_pipe_model (
  input  wire logic        clk_i,       // Core clock
  input  wire logic        res_valid_i, // Completion pulse
  input  wire logic        exc_valid_i, // Exception pulse
  input  wire logic [1:0]  exc_code_i,  // Exception kind
  output logic             op_valid_o,  // Issue strobe
  output logic [2:0]       op_code_o,   // Operation
  output logic [1:0]       acc_sel_o,   // Accumulator select
  output logic [31:0]      src_a_o,     // First source
  output logic [31:0]      src_b_o      // Second source
);
  int         res_cnt = 0;
  int         exc_cnt = 0;
  logic [1:0] exc_last = 2'h0;
  initial begin
    op_valid_o = 1'b0;
    op_code_o = 3'h0;
    acc_sel_o = 2'h0;
    src_a_o = 32'h0;
    src_b_o = 32'h0;
  end
  // Pulses stand one cycle, so they are counted at the edge that ends them
  always @(posedge clk_i) begin
    if (res_valid_i) res_cnt <= res_cnt + 1;
    if (exc_valid_i) exc_cnt <= exc_cnt + 1;
    if (exc_valid_i) exc_last <= exc_code_i;
  end
  // Valid stays up between calls, so back to back issue needs no gap
  task automatic issue(input logic [2:0] c, input logic [1:0] s, input logic [31:0] a, b);
    @(posedge clk_i);
    op_valid_o <= 1'b1;
    op_code_o <= c;
    acc_sel_o <= s;
    src_a_o <= a;
    src_b_o <= b;
  endtask
  // No later issue relies on accumulator zero after a register-result op
  task automatic idle();
    @(posedge clk_i);
    op_valid_o <= 1'b0;
    @(posedge clk_i);
    @(negedge clk_i);
  endtask
endmodule

// ---- verif/fmac_unit_properties.sv ----
// Checker for the multiply unit: issue answers, results and bus handshake.
// Sees only the top module's ports; bound to every instance at the foot.
`timescale 1ns/1ps
module fmac_unit_properties #(
  parameter int NUM_ACC = 4                  // Accumulator count
) (
  input wire logic        core_clk_i,        // Clock
  input wire logic        rstn_i,            // Reset, active low
  input wire logic        op_valid_i,        // Issue strobe
  input wire logic [2:0]  op_code_i,         // Operation
  input wire logic [1:0]  acc_sel_i,         // Accumulator select
  input wire logic [31:0] src_a_i,           // First source
  input wire logic [31:0] src_b_i,           // Second source
  input wire logic        res_valid_o,       // Completion
  input wire logic        res_gpr_we_o,      // Register write
  input wire logic [31:0] res_data_o,        // Register result
  input wire logic        exc_valid_o,       // Exception
  input wire logic [1:0]  exc_code_o,        // Exception kind
  input wire logic        avs_read_i,        // Bus read
  input wire logic        avs_write_i,       // Bus write
  input wire logic        avs_waitrequest_o  // Bus stall
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  // Product of the last issue, so the result is tied to its operands
  logic [63:0] prod_q;
  always_ff @(posedge core_clk_i) prod_q <= $signed(src_a_i) * $signed(src_b_i);

  one_answer_a: assert property (op_valid_i |=> res_valid_o != exc_valid_o)
    else $error("issue did not get exactly one answer");
  reserved_code_a: assert property (op_valid_i && op_code_i > 3'h4 |=>
    exc_valid_o && exc_code_o == fmac_pkg::FMAC_EXC_RESERVED) else $error("bad refusal");
  acc0_signed_word_multiply_to_acc_a: assert property (op_valid_i && op_code_i == 3'h4 &&
    acc_sel_i == 2'h0 |=> res_valid_o && !res_gpr_we_o) else $error("signed_word_multiply_to_acc refused");
  word_sat_a: assert property (op_valid_i && op_code_i == 3'h0 && src_a_i == 32'h80000000
    && src_b_i == 32'h80000000 |=> exc_valid_o || res_data_o == 32'h7fffffff)
    else $error("word product not clipped");
  word_trunc_a: assert property (op_valid_i && op_code_i == 3'h0 &&
    !(src_a_i == 32'h80000000 && src_b_i == 32'h80000000) |=>
    exc_valid_o || res_data_o == prod_q[62:31]) else $error("word product wrong");
  lane_sat_a: assert property (op_valid_i && op_code_i == 3'h1 &&
    src_a_i[15:0] == 16'h8000 && src_b_i[15:0] == 16'h8000 |=>
    exc_valid_o || res_data_o[15:0] == 16'h7fff) else $error("lane not clipped");
  acc_no_gpr_a: assert property (op_valid_i && op_code_i inside {[3'h2:3'h4]} |=>
    !res_gpr_we_o) else $error("accumulator op wrote a register");
  gpr_write_a: assert property (op_valid_i && op_code_i < 3'h2 |=>
    exc_valid_o || res_gpr_we_o) else $error("register result not flagged");
  bus_answer_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=>
    !avs_waitrequest_o ##1 avs_waitrequest_o) else $error("bus answer late");
endmodule

bind fmac_unit fmac_unit_properties #(.NUM_ACC(NUM_ACC)) fmac_unit_properties_inst (
  .core_clk_i, .rstn_i, .op_valid_i, .op_code_i, .acc_sel_i, .src_a_i, .src_b_i,
  .res_valid_o, .res_gpr_we_o, .res_data_o, .exc_valid_o, .exc_code_o,
  .avs_read_i, .avs_write_i, .avs_waitrequest_o
);

// ---- verif/fmac_unit_tb.sv ----
// Self-checking bench: table of register-result ops, then accumulator,
// flag, interrupt, refusal and reset cases. The model drives the issue port.
`timescale 1ns/1ps
module fmac_unit_tb;
  typedef struct {logic [2:0] op; logic [31:0] a, b, q; logic s;} fmac_row_t;
  logic        clk, rstn, op_valid, res_valid, gpr_we, exc_valid, rd_en, wr_en, wt, irq;
  logic [2:0]  op_code;
  logic [1:0]  acc_sel, exc_code;
  logic [31:0] src_a, src_b, res_data, wdat, rdat, v;
  logic [5:0]  adr;
  int          num_errors, checks_done;
  fmac_row_t   rows [7] = '{'{3'h0, 32'h40000000, 32'h40000000, 32'h20000000, 1'b0},
    '{3'h0, 32'h80000000, 32'h80000000, 32'h7fffffff, 1'b1},
    '{3'h0, 32'h80000000, 32'h7fffffff, 32'h80000001, 1'b0},
    '{3'h0, 32'hffffffff, 32'h00000001, 32'hffffffff, 1'b0},
    '{3'h1, 32'h80004000, 32'h80004000, 32'h7fff2000, 1'b1},
    '{3'h1, 32'hc0000001, 32'h4000ffff, 32'he000ffff, 1'b0},
    '{3'h1, 32'h00008000, 32'h00008000, 32'h00007fff, 1'b1}};

  fmac_unit fmac_unit_inst (.core_clk_i(clk), .rstn_i(rstn), .op_valid_i(op_valid),
    .op_code_i(op_code), .acc_sel_i(acc_sel), .src_a_i(src_a), .src_b_i(src_b),
    .res_valid_o(res_valid), .res_gpr_we_o(gpr_we), .res_data_o(res_data),
    .exc_valid_o(exc_valid), .exc_code_o(exc_code), .avs_address_i(adr),
    .avs_read_i(rd_en), .avs_write_i(wr_en), .avs_writedata_i(wdat),
    .avs_byteenable_i(4'hf), .avs_readdata_o(rdat), .avs_waitrequest_o(wt), .irq_o(irq));
  fmac_pipe_model fmac_pipe_model_inst (.clk_i(clk), .res_valid_i(res_valid),
    .exc_valid_i(exc_valid), .exc_code_i(exc_code), .op_valid_o(op_valid),
    .op_code_o(op_code), .acc_sel_o(acc_sel), .src_a_o(src_a), .src_b_o(src_b));

  task automatic chk(input string nm, input logic [63:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One access; request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge clk);
    adr <= a;
    wdat <= d;
    wr_en <= w;
    rd_en <= !w;
    // Only the watchdog ends a wait that never finishes
    do begin
      @(posedge clk);
    end while (wt !== 1'b0);
    r = rdat;
    rd_en <= 1'b0;
    wr_en <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask
  task automatic acc_chk(input logic [1:0] i, input logic [63:0] exp);
    logic [31:0] hi;
    bus(1'b0, fmac_pkg::FMAC_REG_ACC_BASE + {i, 3'h0}, 32'h0, hi);
    bus(1'b0, fmac_pkg::FMAC_REG_ACC_BASE + {i, 3'h4}, 32'h0, v);
    chk("acc", {hi, v}, exp);
  endtask
  task automatic op(input logic [2:0] c, input logic [1:0] s, input logic [31:0] a, b);
    fmac_pipe_model_inst.issue(c, s, a, b);
  endtask
  task automatic idle();
    fmac_pipe_model_inst.idle();
  endtask
  // Interrupt output lags the register write by one edge
  task automatic settle();
    @(posedge clk);
    @(negedge clk);
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // The cases need under two hundred cycles; this is far beyond that
  initial begin
    #200000;
    num_errors++;
    print_verdict();
  end
  initial begin
    {rstn, rd_en, wr_en, adr, wdat, num_errors, checks_done} = '0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    foreach (rows[i]) begin
      op(rows[i].op, 2'h1, rows[i].a, rows[i].b);
      idle();
      chk("gpr", 64'(res_data), 64'(rows[i].q));
      bus(1'b0, fmac_pkg::FMAC_REG_SPCR, 32'h0, v);
      chk("ovf21", 64'(v[21]), 64'(rows[i].s));
      wr(fmac_pkg::FMAC_REG_SPCR, 32'h0);
    end
    // Chain issued back to back; each op after the first must see the previous sum
    wr(fmac_pkg::FMAC_REG_SPCR, 32'h00a50000);
    op(3'h4, 2'h1, 32'hfffffffe, 32'h00000003);
    op(3'h2, 2'h1, 32'h00030002, 32'h00040005);
    op(3'h2, 2'h1, 32'h00017fff, 32'h00017fff);
    idle();
    acc_chk(2'h1, 64'hffffffff_c000fffc);
    bus(1'b0, fmac_pkg::FMAC_REG_SPCR, 32'h0, v);
    chk("ovf", 64'(v[23:16]), 64'ha5);
    wr(fmac_pkg::FMAC_REG_SPCR, 32'h0);
    op(3'h3, 2'h2, 32'h80004000, 32'h80002000);
    op(3'h3, 2'h3, 32'h00004000, 32'h00004000);
    op(3'h0, 2'h0, 32'h80000000, 32'h80000000);
    op(3'h1, 2'h0, 32'h80008000, 32'h80008000);
    idle();
    acc_chk(2'h2, 64'h6fffffff);
    acc_chk(2'h3, 64'hffffffff_e0000000);
    bus(1'b0, fmac_pkg::FMAC_REG_SPCR, 32'h0, v);
    chk("ovf", 64'(v[23:16]), 64'h24);
    // Interrupt: masked out, masked in, then cleared by writing one
    bus(1'b0, fmac_pkg::FMAC_REG_IRQ_STATUS, 32'h0, v);
    chk("status", 64'(v[2:0]), 64'h3);
    chk("irq", 64'(irq), 64'h0);
    wr(fmac_pkg::FMAC_REG_IRQ_MASK, 32'h2);
    settle();
    chk("irq", 64'(irq), 64'h1);
    wr(fmac_pkg::FMAC_REG_IRQ_STATUS, 32'h2);
    settle();
    chk("irq", 64'(irq), 64'h0);
    // Refusals: read-only window, unmapped place, reserved and disabled ops
    wr(fmac_pkg::FMAC_REG_ACC_BASE + 6'h08, 32'h0);
    bus(1'b0, 6'h10, 32'h0, v);
    chk("unmapped", 64'(v), 64'h0);
    for (logic [3:0] c = 4'h5; c < 4'h8; c++) op(c[2:0], 2'h1, 32'h0, 32'h0);
    idle();
    chk("exc", 64'(fmac_pipe_model_inst.exc_cnt), 64'h3);
    chk("code", 64'(fmac_pipe_model_inst.exc_last), 64'h1);
    wr(fmac_pkg::FMAC_REG_CTRL, 32'h0);
    op(3'h3, 2'h1, 32'h80008000, 32'h80008000);
    idle();
    chk("code", 64'(fmac_pipe_model_inst.exc_last), 64'h2);
    op(3'h4, 2'h0, 32'hfffffffe, 32'h00000003);
    idle();
    chk("exc", 64'(fmac_pipe_model_inst.exc_cnt), 64'h4);
    chk("res", 64'(fmac_pipe_model_inst.res_cnt), 64'hf);
    acc_chk(2'h0, 64'hffffffff_fffffffa);
    acc_chk(2'h1, 64'hffffffff_c000fffc);
    // Refused ops set only the exception status bit, no overflow flag
    bus(1'b0, fmac_pkg::FMAC_REG_IRQ_STATUS, 32'h0, v);
    chk("status", 64'(v[2:0]), 64'h5);
    bus(1'b0, fmac_pkg::FMAC_REG_SPCR, 32'h0, v);
    chk("ovf", 64'(v[23:16]), 64'h24);
    // Reset in mid-run returns registers and accumulators to their start
    @(posedge clk);
    rstn <= 1'b0;
    @(negedge clk);
    chk("wait", 64'(wt), 64'h1);
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    bus(1'b0, fmac_pkg::FMAC_REG_CTRL, 32'h0, v);
    chk("ctrl", 64'(v[0]), 64'h1);
    bus(1'b0, fmac_pkg::FMAC_REG_SPCR, 32'h0, v);
    chk("ovf", 64'(v[23:16]), 64'h0);
    bus(1'b0, fmac_pkg::FMAC_REG_IRQ_STATUS, 32'h0, v);
    chk("status", 64'(v[2:0]), 64'h0);
    acc_chk(2'h1, 64'h0);
    print_verdict();
  end
endmodule
